// ---- rtl/pd_status_interrupt_regs.v ----
// Status and read-to-clear interrupt registers of a Type-C / PD port controller.
//
// How it works
// - Soft-reset-failure status, bit 5, sets when all soft reset retries lack GoodCRC.
// - Retry-exhausted status, bit 4, sets when all packet retries lack GoodCRC.
// - Transmit-start, transmitter-on or hard-reset-send command clears both failure bits.
// - Bits 3:2 show the internally requested upper power enables.
// - Effective power is the larger of software field and internal request combination.
// - Soft-reset-received status, bit 1, sets when a soft reset packet arrives.
// - Hard-reset-received status, bit 0, sets when hard reset ordered set arrives.
// - Toggle settle code 000 while automatic toggling still runs.
// - Code 001 settled source CC1, 010 settled source CC2.
// - Code 101 settled sink CC1, 110 settled sink CC2.
// - Code 111 audio accessory, Ra on both lines; other codes undefined.
// - Bit 0 of toggle/SOP status marks last received packet as SOP.
// - Bit 1 marks SOP prime debug, bit 2 SOP double prime debug.
// - Interrupt bit 7 latches on VCONN overcurrent or over-temperature.
// - Interrupt bit 6 latches when toggling ends on a detected attach.
// - Interrupt bit 5 on soft reset failure, bit 4 on retry exhaustion.
// - Interrupt bit 3 latches after a hard reset is sent successfully.
// - Interrupt bit 2 latches when a sent packet gets GoodCRC.
// - Interrupt bit 1 on received soft reset, bit 0 on received hard reset.
// - Second interrupt register bit 0 latches after sending a GoodCRC reply.
// - Each interrupt flag has its own software mask bit gating the request.
`timescale 1ns/1ps
`default_nettype none
`include "pd_status_map.vh"
module pd_status_interrupt_regs (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Register read port from the I2C slave, same clock domain.
    input wire reg_read,
    input wire [7:0] reg_addr,
    output reg [7:0] reg_rdata_q,
    // Transmit commands.
    input wire start_tx_cmd,
    input wire transmitter_on_cmd,
    input wire send_hard_reset_cmd,
    // Protocol events from the PD transmitter and receiver, one-cycle pulses.
    input wire soft_reset_fail_evt,
    input wire retry_exhausted_evt,
    input wire hard_reset_sent_evt,
    input wire tx_acked_evt,
    input wire soft_reset_rx_evt,
    input wire hard_reset_rx_evt,
    input wire ack_sent_evt,
    // Receive FIFO packet type, valid with rx_packet_stored.
    input wire rx_packet_stored,
    input wire rx_plain_sop,
    input wire rx_prime_debug,
    input wire rx_dprime_debug,
    // Toggle state machine.
    input wire toggle_start,
    input wire toggle_done,
    input wire [2:0] toggle_result,
    input wire role_detect_done_evt,
    // Protection events, asynchronous pins.
    input wire overcurrent_vconn1,
    input wire overcurrent_vconn2,
    input wire over_temperature,
    // Power control.
    input wire [3:0] power_enable_field,
    input wire [1:0] internal_power_request,
    output reg [3:0] effective_power_q,
    // Interrupt masks from the mask registers.
    input wire [7:0] event_mask,
    input wire ack_sent_mask,
    // Interrupt request.
    output reg irq_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise the protection pins and detect a new fault.

    wire [2:0] prot_pins = {over_temperature, overcurrent_vconn2, overcurrent_vconn1};
    reg [2:0] prot_s1_q;
    reg [2:0] prot_s2_q;
    reg [2:0] prot_s3_q;
    reg [2:0] prot_level_q;
    wire [2:0] prot_level_d;
    wire prot_rise;

    // Three stages cost three cycles of latency on a fault pin, which is slow next to the clock.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prot_s1_q <= 3'h0;
            prot_s2_q <= 3'h0;
            prot_s3_q <= 3'h0;
            prot_level_q <= 3'h0;
        end else begin
            prot_s1_q <= prot_pins;
            prot_s2_q <= prot_s1_q;
            prot_s3_q <= prot_s2_q;
            prot_level_q <= prot_level_d;
        end
    end

    // A pin counts as changed only once the second and third stages agree.
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_prot
            assign prot_level_d[p] = (prot_s2_q[p] == prot_s3_q[p]) ? prot_s2_q[p] : prot_level_q[p];
        end
    endgenerate
    assign prot_rise = |(prot_level_d & ~prot_level_q);

    ////////////////////////////////////////////////////////////////////////////
    // Reset status register.

    reg soft_reset_fail_q;
    reg retry_exhausted_q;
    reg soft_reset_seen_q;
    reg hard_reset_seen_q;
    reg [1:0] power_req_q;
    wire tx_command = start_tx_cmd | transmitter_on_cmd | send_hard_reset_cmd;

    // A failure reported in the same cycle as a new command is kept, since it
    // belongs to the earlier transfer and software must still see it.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_fail_q <= 1'b0;
            retry_exhausted_q <= 1'b0;
            soft_reset_seen_q <= 1'b0;
            hard_reset_seen_q <= 1'b0;
            power_req_q <= 2'h0;
        end else begin
            if (soft_reset_fail_evt) begin
                soft_reset_fail_q <= 1'b1;
            end else if (tx_command) begin
                soft_reset_fail_q <= 1'b0;
            end
            if (retry_exhausted_evt) begin
                retry_exhausted_q <= 1'b1;
            end else if (tx_command) begin
                retry_exhausted_q <= 1'b0;
            end
            if (soft_reset_rx_evt) begin
                soft_reset_seen_q <= 1'b1;
            end
            if (hard_reset_rx_evt) begin
                hard_reset_seen_q <= 1'b1;
            end
            power_req_q <= internal_power_request;
        end
    end

    // Fields are placed by their named positions so the map header stays the one source.
    wire [7:0] reset_status;
    assign reset_status[7:6] = 2'h0;
    assign reset_status[`BIT_SOFT_RESET_FAIL] = soft_reset_fail_q;
    assign reset_status[`BIT_RETRY_EXHAUSTED] = retry_exhausted_q;
    assign reset_status[`BIT_POWER_REQ_HI:`BIT_POWER_REQ_LO] = power_req_q;
    assign reset_status[`BIT_SOFT_RESET_SEEN] = soft_reset_seen_q;
    assign reset_status[`BIT_HARD_RESET_SEEN] = hard_reset_seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // Effective power state.

    wire [3:0] power_combined = {power_req_q, power_enable_field[1:0]};
    reg [3:0] effective_power_d;

    // Comparing whole nibbles keeps the lower software bits in both candidates.
    always @* begin
        if (power_combined > power_enable_field) begin
            effective_power_d = power_combined;
        end else begin
            effective_power_d = power_enable_field;
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            effective_power_q <= `RST_POWER_ENABLE;
        end else begin
            effective_power_q <= effective_power_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle and SOP status register.

    reg [2:0] toggle_state_q;
    reg [2:0] toggle_state_d;
    reg [2:0] sop_type_q;

    // An undefined settle code keeps the last report, so software never sees a code it must not interpret.
    always @* begin
        toggle_state_d = toggle_state_q;
        if (toggle_start) begin
            toggle_state_d = `TOG_RUNNING;
        end else if (toggle_done) begin
            case (toggle_result)
                `TOG_SRC_CC1: toggle_state_d = `TOG_SRC_CC1;
                `TOG_SRC_CC2: toggle_state_d = `TOG_SRC_CC2;
                `TOG_SNK_CC1: toggle_state_d = `TOG_SNK_CC1;
                `TOG_SNK_CC2: toggle_state_d = `TOG_SNK_CC2;
                `TOG_AUDIO: toggle_state_d = `TOG_AUDIO;
                default: toggle_state_d = toggle_state_q;
            endcase
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            toggle_state_q <= `TOG_RUNNING;
            sop_type_q <= 3'h0;
        end else begin
            toggle_state_q <= toggle_state_d;
            if (rx_packet_stored) begin
                sop_type_q <= {rx_dprime_debug, rx_prime_debug, rx_plain_sop};
            end
        end
    end

    wire [7:0] toggle_sop_status;
    assign toggle_sop_status[7:6] = 2'h0;
    assign toggle_sop_status[`BIT_TOGGLE_HI:`BIT_TOGGLE_LO] = toggle_state_q;
    assign toggle_sop_status[`BIT_RX_DPRIME_DEBUG] = sop_type_q[2];
    assign toggle_sop_status[`BIT_RX_PRIME_DEBUG] = sop_type_q[1];
    assign toggle_sop_status[`BIT_RX_PLAIN_SOP] = sop_type_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flag registers.

    wire read_event_flags = reg_read && (reg_addr == `ADDR_PD_EVENT_FLAGS);
    wire read_ack_flag = reg_read && (reg_addr == `ADDR_GOODCRC_EVENT_FLAG);
    wire [7:0] event_pulse;
    wire [7:0] event_flags;
    wire [7:0] ack_flags;

    assign event_pulse[`BIT_OVERCURRENT_HEAT] = prot_rise;
    assign event_pulse[`BIT_ROLE_DETECT_DONE] = role_detect_done_evt;
    assign event_pulse[`BIT_SOFT_FAIL_EVT] = soft_reset_fail_evt;
    assign event_pulse[`BIT_RETRY_FAIL_EVT] = retry_exhausted_evt;
    assign event_pulse[`BIT_HARD_SENT_EVT] = hard_reset_sent_evt;
    assign event_pulse[`BIT_TX_ACKED_EVT] = tx_acked_evt;
    assign event_pulse[`BIT_SOFT_RX_EVT] = soft_reset_rx_evt;
    assign event_pulse[`BIT_HARD_RX_EVT] = hard_reset_rx_evt;

    event_flag_bank u_event_flags (
        .clock(clock),
        .reset_n(reset_n),
        .event_pulse(event_pulse),
        .clear_read(read_event_flags),
        .flags_q(event_flags)
    );

    // Only bit 0 of the second register is live; the rest never set.
    wire [7:0] ack_pulse = {7'h00, ack_sent_evt};

    event_flag_bank u_ack_flag (
        .clock(clock),
        .reset_n(reset_n),
        .event_pulse(ack_pulse),
        .clear_read(read_ack_flag),
        .flags_q(ack_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request and read data.

    // Registered so the request pin never glitches; it trails its flag by one cycle.
    wire irq_d = |(event_flags & ~event_mask) | (ack_flags[0] & ~ack_sent_mask);
    reg [7:0] reg_rdata_d;

    // The read returns the flags as they stood before the clear takes effect.
    always @* begin
        reg_rdata_d = reg_rdata_q;
        if (reg_read) begin
            case (reg_addr)
                `ADDR_PD_RESET_STATUS: reg_rdata_d = reset_status;
                `ADDR_TOGGLE_SOP_STATUS: reg_rdata_d = toggle_sop_status;
                `ADDR_PD_EVENT_FLAGS: reg_rdata_d = event_flags;
                `ADDR_GOODCRC_EVENT_FLAG: reg_rdata_d = ack_flags;
                default: reg_rdata_d = `RST_REG8;
            endcase
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            reg_rdata_q <= `RST_REG8;
        end else begin
            irq_q <= irq_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/pd_status_map.vh ----
// Register offsets, field positions, codes and reset values for the PD status and interrupt registers.
`ifndef PD_STATUS_MAP_VH
`define PD_STATUS_MAP_VH

`define ADDR_PD_RESET_STATUS 8'h3c
`define ADDR_TOGGLE_SOP_STATUS 8'h3d
`define ADDR_PD_EVENT_FLAGS 8'h3e
`define ADDR_GOODCRC_EVENT_FLAG 8'h3f

`define RST_REG8 8'h00

`define BIT_SOFT_RESET_FAIL 5
`define BIT_RETRY_EXHAUSTED 4
`define BIT_POWER_REQ_HI 3
`define BIT_POWER_REQ_LO 2
`define BIT_SOFT_RESET_SEEN 1
`define BIT_HARD_RESET_SEEN 0

`define BIT_TOGGLE_HI 5
`define BIT_TOGGLE_LO 3
`define BIT_RX_DPRIME_DEBUG 2
`define BIT_RX_PRIME_DEBUG 1
`define BIT_RX_PLAIN_SOP 0

`define BIT_OVERCURRENT_HEAT 7
`define BIT_ROLE_DETECT_DONE 6
`define BIT_SOFT_FAIL_EVT 5
`define BIT_RETRY_FAIL_EVT 4
`define BIT_HARD_SENT_EVT 3
`define BIT_TX_ACKED_EVT 2
`define BIT_SOFT_RX_EVT 1
`define BIT_HARD_RX_EVT 0
`define BIT_ACK_SENT_EVT 0

`define TOG_RUNNING 3'h0
`define TOG_SRC_CC1 3'h1
`define TOG_SRC_CC2 3'h2
`define TOG_SNK_CC1 3'h5
`define TOG_SNK_CC2 3'h6
`define TOG_AUDIO 3'h7

`define RST_POWER_ENABLE 4'h1

`endif

// ---- rtl/event_flag_bank.v ----
// Eight read-to-clear event flags where a new event outranks the clearing read.
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Events and read-clear strobe.
    input wire [7:0] event_pulse,
    input wire clear_read,
    // Flag state.
    output reg [7:0] flags_q
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            always @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    flags_q[i] <= 1'b0;
                end else if (event_pulse[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clear_read) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verification/pd_regs_properties.sv ----
// Concurrent checks on the ports of the PD status and interrupt registers.
`timescale 1ns/1ps
`default_nettype none
`include "pd_status_map.vh"
module pd_regs_properties (
    // Clock, reset and read port.
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_q,
    // Events, toggle, power and masks.
    input wire logic tx_acked_evt,
    input wire logic hard_reset_rx_evt,
    input wire logic ack_sent_evt,
    input wire logic toggle_start,
    input wire logic toggle_done,
    input wire logic [3:0] power_enable_field,
    input wire logic [1:0] internal_power_request,
    input wire logic [7:0] event_mask,
    input wire logic ack_sent_mask,
    // Outputs.
    input wire logic [3:0] effective_power_q,
    input wire logic irq_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire [3:0] pwr_mix = {internal_power_request, power_enable_field[1:0]};
    wire [3:0] pwr_want = (pwr_mix > power_enable_field) ? pwr_mix : power_enable_field;
    sequence s_rd_b;
        reg_read && reg_addr == `ADDR_GOODCRC_EVENT_FLAG && !ack_sent_evt;
    endsequence
    sequence s_tog_run;
        toggle_start && !toggle_done ##1 !toggle_done ##1 !toggle_done && reg_read && reg_addr == 8'h3d;
    endsequence
    // The power check waits for reset to have been up, since the reset value is not the larger value.
    sequence s_pwr_calm;
        $stable(power_enable_field) && $stable(internal_power_request) && $past(reset_n);
    endsequence
    a_irq_hard_rx: assert property (hard_reset_rx_evt && !event_mask[0] ##1 !event_mask[0] |=> irq_q)
        else $error("hard reset receipt raised no request");
    a_irq_tx_acked: assert property (tx_acked_evt && !event_mask[2] ##1 !event_mask[2] |=> irq_q)
        else $error("acknowledged send raised no request");
    a_irq_ack_sent: assert property (ack_sent_evt && !ack_sent_mask ##1 !ack_sent_mask |=> irq_q)
        else $error("sent acknowledge raised no request");
    a_irq_masked: assert property ((&event_mask && ack_sent_mask) [*3] |-> !irq_q)
        else $error("request with every flag masked");
    a_unmapped_zero: assert property (reg_read && reg_addr[7:2] != 6'h0f |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_read_clears: assert property (s_rd_b ##1 !ack_sent_evt ##1 s_rd_b |=> reg_rdata_q == 8'h00)
        else $error("flag survived its read");
    a_toggle_running: assert property (s_tog_run |=> reg_rdata_q[5:3] == `TOG_RUNNING)
        else $error("toggle start not reported as running");
    a_power_max: assert property (s_pwr_calm [*3] |-> effective_power_q == pwr_want)
        else $error("effective power not the larger value");
endmodule
bind pd_status_interrupt_regs pd_regs_properties chk_u (.clock, .reset_n, .reg_read, .reg_addr, .reg_rdata_q,
    .tx_acked_evt, .hard_reset_rx_evt, .ack_sent_evt, .toggle_start, .toggle_done, .power_enable_field,
    .internal_power_request, .event_mask, .ack_sent_mask, .effective_power_q, .irq_q);
`default_nettype wire

// ---- verification/host_reader.sv ----
// Host processor model that reads the status and flag registers.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // Clock.
    input wire logic clock,
    // Register read port.
    output logic reg_read,
    output logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_q
);
    initial begin
        reg_read = 1'b0;
        reg_addr = 8'h00;
    end
    // The address shows its inverse once released, so a design that samples late sees a wrong place.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the PD status and interrupt registers.
`timescale 1ns/1ps
`default_nettype none
`include "pd_status_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    typedef struct {logic [10:0] e; logic [7:0] a; logic [7:0] b;} row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [10:0] ev = '0;
    logic [2:0] cmd = '0, tog_res = '0, rx_type = '0, prot = '0;
    logic [3:0] pef = '0;
    logic [1:0] preq = '0;
    logic [7:0] emask = '0, rdata;
    logic bmask = 1'b0;
    wire reg_read, irq;
    wire [7:0] reg_addr, rdq;
    wire [3:0] epwr;
    int failures = 0;
    int checked = 0;
    row_t rows [8] = '{'{11'h1, 8'h20, 8'h00}, '{11'h2, 8'h10, 8'h00}, '{11'h4, 8'h08, 8'h00},
        '{11'h8, 8'h04, 8'h00}, '{11'h10, 8'h02, 8'h00}, '{11'h20, 8'h01, 8'h00},
        '{11'h40, 8'h00, 8'h01}, '{11'h80, 8'h40, 8'h00}};
    logic [9:0] pw [4] = '{10'h0ff, 10'h3cf, 10'h196, 10'h169};
    logic [2:0] tc [6] = '{`TOG_SRC_CC1, `TOG_SRC_CC2, `TOG_SNK_CC1, `TOG_SNK_CC2, `TOG_AUDIO, 3'h3};
    always #12.5 clock = ~clock;
    host_reader host_u (.clock(clock), .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata_q(rdq));
    pd_status_interrupt_regs dut_u (.clock(clock), .reset_n(reset_n), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_rdata_q(rdq), .start_tx_cmd(cmd[0]), .transmitter_on_cmd(cmd[1]), .send_hard_reset_cmd(cmd[2]),
        .soft_reset_fail_evt(ev[0]), .retry_exhausted_evt(ev[1]), .hard_reset_sent_evt(ev[2]),
        .tx_acked_evt(ev[3]), .soft_reset_rx_evt(ev[4]), .hard_reset_rx_evt(ev[5]), .ack_sent_evt(ev[6]),
        .role_detect_done_evt(ev[7]), .toggle_start(ev[8]), .toggle_done(ev[9]), .rx_packet_stored(ev[10]),
        .rx_plain_sop(rx_type[0]), .rx_prime_debug(rx_type[1]), .rx_dprime_debug(rx_type[2]),
        .toggle_result(tog_res), .overcurrent_vconn1(prot[0]), .overcurrent_vconn2(prot[1]),
        .over_temperature(prot[2]), .power_enable_field(pef), .internal_power_request(preq),
        .effective_power_q(epwr), .event_mask(emask), .ack_sent_mask(bmask), .irq_q(irq));
    task automatic pulse(input logic [10:0] e, input logic [2:0] c);
        @(posedge clock);
        ev <= e;
        cmd <= c;
        @(posedge clock);
        ev <= '0;
        cmd <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        host_u.rd(a, rdata);
        `CHK(rdata & m, x)
    endtask
    task automatic end_of_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        `CHK(epwr, `RST_POWER_ENABLE)
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(8'h3c + i[7:0], 8'hff, 8'h00);
        foreach (rows[i]) begin
            pulse(rows[i].e, 3'h0);
            rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, rows[i].a);
            rd_chk(`ADDR_GOODCRC_EVENT_FLAG, 8'hff, rows[i].b);
        end
        rd_chk(`ADDR_PD_RESET_STATUS, 8'hff, 8'h33);
        for (int i = 0; i < 3; i++) begin
            pulse(11'h0, 3'h1 << i);
            rd_chk(`ADDR_PD_RESET_STATUS, 8'h30, 8'h00);
            pulse(11'h3, 3'h1 << i);
            rd_chk(`ADDR_PD_RESET_STATUS, 8'h30, 8'h30);
            rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, 8'h30);
        end
        foreach (pw[i]) begin
            @(posedge clock);
            {pef, preq} <= pw[i][9:4];
            repeat (4) @(posedge clock);
            `CHK(epwr, pw[i][3:0])
            rd_chk(`ADDR_PD_RESET_STATUS, 8'h0c, {4'h0, pw[i][5:4], 2'h0});
        end
        foreach (tc[i]) begin
            @(posedge clock);
            tog_res <= tc[i];
            pulse(11'h200, 3'h0);
            rd_chk(`ADDR_TOGGLE_SOP_STATUS, 8'h38, {2'h0, (i < 5) ? tc[i] : 3'h7, 3'h0});
        end
        // A settled code must fall back to running when toggling starts again.
        pulse(11'h100, 3'h0);
        rd_chk(`ADDR_TOGGLE_SOP_STATUS, 8'h38, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            rx_type <= 3'h1 << i;
            prot <= 3'h1 << i;
            pulse(11'h400, 3'h0);
            rd_chk(`ADDR_TOGGLE_SOP_STATUS, 8'h07, 8'h01 << i);
            prot <= 3'h0;
            repeat (8) @(posedge clock);
            rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, 8'h80);
        end
        // An event landing on the clearing read must survive it.
        pulse(11'h20, 3'h0);
        fork
            host_u.rd(`ADDR_PD_EVENT_FLAGS, rdata);
            pulse(11'h8, 3'h0);
        join
        `CHK(rdata, 8'h01)
        rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, 8'h04);
        emask <= 8'hff;
        bmask <= 1'b1;
        pulse(11'hff, 3'h0);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        emask <= 8'h00;
        bmask <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b1)
        rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, 8'h7f);
        rd_chk(`ADDR_GOODCRC_EVENT_FLAG, 8'hff, 8'h01);
        rd_chk(`ADDR_GOODCRC_EVENT_FLAG, 8'hff, 8'h00);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        // A reset in mid-run must wipe flags, status and the request alike.
        pulse(11'h47f, 3'h0);
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        `CHK(irq, 1'b0)
        `CHK(epwr, `RST_POWER_ENABLE)
        reset_n <= 1'b1;
        rd_chk(`ADDR_PD_RESET_STATUS, 8'hf3, 8'h00);
        rd_chk(`ADDR_TOGGLE_SOP_STATUS, 8'hff, 8'h00);
        rd_chk(`ADDR_PD_EVENT_FLAGS, 8'hff, 8'h00);
        rd_chk(`ADDR_GOODCRC_EVENT_FLAG, 8'hff, 8'h00);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
